// ===== rtl/atp_regs.vh
// Register map, field positions, reset values and timing constants for the aftertreatment block.
// Summary of operation
// - Consent goes out while the generator breaker is open, unless a consent input is configured.
// - Breaker open with regeneration running suppresses overspeed and overfrequency protections only.
// - Regeneration mode 0 sends neither force nor inhibit; consent is still handled.
// - Mode 1 written by software asserts force for at most the configured seconds, then mode returns to 0.
// - Mode 2 asserts inhibit continuously.
// - Configured inhibit or force inputs set the mode; software writes to mode are rejected.
// - Inhibit and force travel on CAN parameters 3695 and 3696 and on discrete outputs.
// - Active regeneration status 0, 1, 2 decodes to not active, active, starting soon.
// - Filter status 0 to 3 decodes to four exclusive need flags.
// - Tank level comes from CAN unless level contact inputs are configured.
// - Level below start gives start, else above stop gives stop, else hysteresis.
// - A level contact is asserted while the level lies below its threshold.
// - Automatic pump mode starts on start, stops on stop, holds on hysteresis.
// - Manual-on runs except on stop; manual-off keeps the pump stopped.
// - With no pump output configured the pump function is disabled; the valve is optional.
// - Valve opens a delay before the pump starts and closes a delay after it stops.
// - Controller off for five seconds continuously stops the pump.
// - Pump supply source unavailable for at least 5 seconds stops the pump.
// - Run time over the configured maximum stops the pump and raises the failure alarm.
// - Latched stop anomalies keep the pump off until acknowledged.
// - With the event enable bit set, start and stop events are logged per transition.
`ifndef ATP_REGS_VH
`define ATP_REGS_VH

// Word addresses on the Wishbone bus, one per register.
`define ATP_ADR_CFG      4'h0
`define ATP_ADR_REGEN    4'h1
`define ATP_ADR_PUMP     4'h2
`define ATP_ADR_THR      4'h3
`define ATP_ADR_DELAY    4'h4
`define ATP_ADR_STAT     4'h5
`define ATP_ADR_ACK      4'h6
`define ATP_ADR_EVT      4'h7

// Configuration register fields.
`define ATP_CFG_CONS_IN  0
`define ATP_CFG_INH_IN   1
`define ATP_CFG_FRC_IN   2
`define ATP_CFG_LVL_IN   3
`define ATP_CFG_PUMP_OUT 4
`define ATP_CFG_VALV_OUT 5
`define ATP_CFG_EVT_EN   7

// Regeneration modes.
`define ATP_RG_AUTO      2'h0
`define ATP_RG_FORCE     2'h1
`define ATP_RG_INHIBIT   2'h2

// Received active regeneration status codes.
`define ATP_RS_ACTIVE    2'h1
`define ATP_RS_UNDEF     2'h3

// Pump modes.
`define ATP_PM_OFF       2'h0
`define ATP_PM_ON        2'h1
`define ATP_PM_AUTO      2'h2

// Supply source selection.
`define ATP_SRC_GEN      3'h0
`define ATP_SRC_BUS      3'h1
`define ATP_SRC_LOAD     3'h2
`define ATP_SRC_MAINS    3'h3
`define ATP_SRC_ALWAYS   3'h4

// Reset values.
`define ATP_CFG_RST      8'h10
`define ATP_THR_RST      16'h5014
`define ATP_DLY_RST      16'h0202

// Fixed guard times in seconds.
`define ATP_OFF_SEC      8'h05
`define ATP_SRC_SEC      8'h05

`endif

// ===== rtl/atp_sec_timer.v
// Seconds counter that measures how long a condition has held.
`timescale 1ns/10ps
`default_nettype none

module atp_sec_timer #(
	parameter W = 16
) (
	input  wire         clk_i,
	input  wire         rst_i,
	input  wire         run_i,
	input  wire         tick_i,
	output reg  [W-1:0] secs_o
);

	// Restart at zero whenever the condition drops; saturate so a long hold never wraps.
	always @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			secs_o <= {W{1'b0}};
		end else if (tick_i && secs_o != {W{1'b1}}) begin
			secs_o <= secs_o + {{(W-1){1'b0}}, 1'b1};
		end
	end

endmodule // atp_sec_timer
`default_nettype wire

// ===== rtl/atp_ctrl.v
// Aftertreatment regeneration commands, status decode and exhaust-fluid pump control.
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "atp_regs.vh"

module atp_ctrl #(
	parameter CLK_HZ  = 100000000,
	parameter TICK_CY = 100000000
) (
	input  wire        clk_i,
	input  wire        rst_i,
	// Classic Wishbone slave.
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [3:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// Plant inputs.
	input  wire        generator_breaker_closed_i,
	input  wire        regen_consent_input_i,
	input  wire        regen_inhibit_input_i,
	input  wire        regen_force_input_i,
	input  wire [1:0]  can_regen_status_i,
	input  wire [1:0]  can_filter_status_i,
	input  wire [7:0]  can_tank_level_i,
	input  wire        start_level_contact_i,
	input  wire        stop_level_contact_i,
	input  wire        ctrl_off_mode_i,
	input  wire [4:0]  source_avail_i,
	// Plant outputs.
	output reg         regen_consent_o,
	output reg         overspeed_suppress_o,
	output reg         can_spn3695_inhibit_o,
	output reg         can_spn3696_force_o,
	output reg         regen_inhibit_output_o,
	output reg         regen_force_output_o,
	output reg  [2:0]  regen_active_flags_o,
	output reg  [3:0]  filter_need_flags_o,
	output reg         pump_output_o,
	output reg         valve_output_o,
	output reg         pump_failure_alarm_o,
	output reg         pump_started_event_o,
	output reg         pump_stopped_event_o
);

	// Valve sequencer states, one-hot.
	localparam [3:0] VS_IDLE  = 4'h1;
	localparam [3:0] VS_PRE   = 4'h2;
	localparam [3:0] VS_RUN   = 4'h4;
	localparam [3:0] VS_POST  = 4'h8;

	reg  [7:0]  cfg_r;
	reg  [1:0]  regen_mode_r;
	reg  [15:0] force_max_r;
	reg  [1:0]  pump_mode_r;
	reg  [2:0]  src_sel_r;
	reg  [15:0] run_max_r;
	reg  [7:0]  thr_start_r;
	reg  [7:0]  thr_stop_r;
	reg  [7:0]  dly_open_r;
	reg  [7:0]  dly_close_r;
	reg  [31:0] tick_cnt_r;
	reg         tick_r;
	reg         pump_cmd_r;
	reg         pump_cmd_nxt;
	reg         off_lat_r;
	reg         src_lat_r;
	reg         run_lat_r;
	reg  [3:0]  vs_r;
	reg  [7:0]  vs_cnt_r;
	reg  [15:0] evt_start_cnt_r;
	reg  [15:0] evt_stop_cnt_r;
	reg  [1:0]  lvl_stat;
	reg         src_ok;

	wire [15:0] force_secs;
	wire [15:0] off_secs;
	wire [15:0] src_secs;
	wire [15:0] run_secs;
	wire        bus_req;
	wire        bus_wr;
	wire        pin_mode;
	wire [1:0]  mode_eff;
	wire        pump_en;
	wire        stop_latched;
	wire        ack_wr;

	// Level status codes.
	localparam [1:0] LS_START = 2'h0;
	localparam [1:0] LS_STOP  = 2'h1;
	localparam [1:0] LS_HYST  = 2'h2;

	assign bus_req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr       = bus_req && wb_we_i && wb_sel_i[0];
	assign pin_mode     = cfg_r[`ATP_CFG_INH_IN] || cfg_r[`ATP_CFG_FRC_IN];
	assign pump_en      = cfg_r[`ATP_CFG_PUMP_OUT];
	assign stop_latched = off_lat_r || src_lat_r || run_lat_r;
	assign ack_wr       = bus_wr && wb_adr_i == `ATP_ADR_ACK;

	// Inputs take the mode when configured; inhibit wins if both are raised.
	assign mode_eff = !pin_mode ? regen_mode_r :
		(cfg_r[`ATP_CFG_INH_IN] && regen_inhibit_input_i) ? `ATP_RG_INHIBIT :
		(cfg_r[`ATP_CFG_FRC_IN] && regen_force_input_i) ? `ATP_RG_FORCE :
		`ATP_RG_AUTO;

	// Level classification shared by both transducer kinds.
	function [1:0] classify;
		input below_start;
		input above_stop;
		begin
			if (below_start) begin
				classify = LS_START;
			end else if (above_stop) begin
				classify = LS_STOP;
			end else begin
				classify = LS_HYST;
			end
		end
	endfunction

	// One-second timebase shared by all timers.
	always @(posedge clk_i) begin
		if (rst_i || tick_cnt_r == TICK_CY - 1) begin
			tick_cnt_r <= 32'h0;
		end else begin
			tick_cnt_r <= tick_cnt_r + 32'h1;
		end
		tick_r <= !rst_i && tick_cnt_r == TICK_CY - 1;
	end

	// Contacts replace the CAN level; a stop contact low means the tank is above stop.
	always @* begin
		if (cfg_r[`ATP_CFG_LVL_IN]) begin
			lvl_stat = classify(start_level_contact_i, !stop_level_contact_i);
		end else begin
			lvl_stat = classify(can_tank_level_i < thr_start_r,
				can_tank_level_i > thr_stop_r);
		end
	end

	// Supply source selection.
	always @* begin
		case (src_sel_r)
			`ATP_SRC_GEN:   src_ok = source_avail_i[0];
			`ATP_SRC_BUS:   src_ok = source_avail_i[1];
			`ATP_SRC_LOAD:  src_ok = source_avail_i[2];
			`ATP_SRC_MAINS: src_ok = source_avail_i[3];
			default:        src_ok = 1'b1;
		endcase
	end

	// Demanded pump command from mode and level.
	always @* begin
		pump_cmd_nxt = pump_cmd_r;
		case (pump_mode_r)
			`ATP_PM_AUTO: begin
				if (lvl_stat == LS_START) begin
					pump_cmd_nxt = 1'b1;
				end else if (lvl_stat == LS_STOP) begin
					pump_cmd_nxt = 1'b0;
				end
			end
			`ATP_PM_ON:   pump_cmd_nxt = lvl_stat != LS_STOP;
			default:      pump_cmd_nxt = 1'b0;
		endcase
		if (!pump_en || stop_latched) begin
			pump_cmd_nxt = 1'b0;
		end
	end

	atp_sec_timer #(.W(16)) u_force_tmr (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.run_i  (regen_mode_r == `ATP_RG_FORCE && !pin_mode),
		.tick_i (tick_r),
		.secs_o (force_secs)
	);

	atp_sec_timer #(.W(16)) u_off_tmr (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.run_i  (ctrl_off_mode_i),
		.tick_i (tick_r),
		.secs_o (off_secs)
	);

	atp_sec_timer #(.W(16)) u_src_tmr (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.run_i  (!src_ok),
		.tick_i (tick_r),
		.secs_o (src_secs)
	);

	atp_sec_timer #(.W(16)) u_run_tmr (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.run_i  (pump_cmd_r),
		.tick_i (tick_r),
		.secs_o (run_secs)
	);

	// Register writes; the forcing timeout writes the mode back to automatic.
	always @(posedge clk_i) begin
		if (rst_i) begin
			cfg_r        <= `ATP_CFG_RST;
			regen_mode_r <= `ATP_RG_AUTO;
			force_max_r  <= 16'h0;
			pump_mode_r  <= `ATP_PM_OFF;
			src_sel_r    <= `ATP_SRC_ALWAYS;
			run_max_r    <= 16'h0;
			{thr_stop_r, thr_start_r} <= `ATP_THR_RST;
			{dly_close_r, dly_open_r} <= `ATP_DLY_RST;
		end else begin
			if (bus_wr) begin
				case (wb_adr_i)
					`ATP_ADR_CFG: cfg_r <= wb_dat_i[7:0];
					`ATP_ADR_REGEN: begin
						if (!pin_mode) begin
							regen_mode_r <= wb_dat_i[1:0];
						end
						force_max_r <= wb_dat_i[31:16];
					end
					`ATP_ADR_PUMP: begin
						pump_mode_r <= wb_dat_i[1:0];
						src_sel_r   <= wb_dat_i[6:4];
						run_max_r   <= wb_dat_i[31:16];
					end
					`ATP_ADR_THR:   {thr_stop_r, thr_start_r} <= wb_dat_i[15:0];
					`ATP_ADR_DELAY: {dly_close_r, dly_open_r} <= wb_dat_i[15:0];
					default: ;
				endcase
			end
			if (regen_mode_r == `ATP_RG_FORCE && !pin_mode && force_secs >= force_max_r) begin
				regen_mode_r <= `ATP_RG_AUTO;
			end
		end
	end

	// Stop anomalies latch; a new cause in the acknowledge cycle wins over the clear.
	always @(posedge clk_i) begin
		if (rst_i) begin
			off_lat_r <= 1'b0;
			src_lat_r <= 1'b0;
			run_lat_r <= 1'b0;
		end else begin
			off_lat_r <= (off_lat_r && !(ack_wr && wb_dat_i[0]))
				|| off_secs >= {8'h0, `ATP_OFF_SEC};
			src_lat_r <= (src_lat_r && !(ack_wr && wb_dat_i[1]))
				|| src_secs >= {8'h0, `ATP_SRC_SEC};
			run_lat_r <= (run_lat_r && !(ack_wr && wb_dat_i[2]))
				|| (run_max_r != 16'h0 && run_secs > run_max_r);
		end
	end

	// Valve leads the pump and trails it; without a valve the pump follows directly.
	always @(posedge clk_i) begin
		if (rst_i) begin
			vs_r       <= VS_IDLE;
			vs_cnt_r   <= 8'h0;
			pump_cmd_r <= 1'b0;
		end else begin
			pump_cmd_r <= pump_cmd_nxt;
			if (tick_r) begin
				vs_cnt_r <= vs_cnt_r + 8'h1;
			end
			case (vs_r)
				VS_IDLE: if (pump_cmd_r) begin
					vs_r     <= cfg_r[`ATP_CFG_VALV_OUT] ? VS_PRE : VS_RUN;
					vs_cnt_r <= 8'h0;
				end
				VS_PRE: if (!pump_cmd_r) begin
					vs_r <= VS_IDLE;
				end else if (vs_cnt_r >= dly_open_r) begin
					vs_r <= VS_RUN;
				end
				VS_RUN: if (!pump_cmd_r) begin
					vs_r     <= cfg_r[`ATP_CFG_VALV_OUT] ? VS_POST : VS_IDLE;
					vs_cnt_r <= 8'h0;
				end
				VS_POST: if (vs_cnt_r >= dly_close_r) begin
					vs_r <= VS_IDLE;
				end
				default: vs_r <= VS_IDLE;
			endcase
		end
	end

	// Plant outputs, all registered.
	always @(posedge clk_i) begin
		if (rst_i) begin
			regen_consent_o        <= 1'b0;
			overspeed_suppress_o   <= 1'b0;
			can_spn3695_inhibit_o  <= 1'b0;
			can_spn3696_force_o    <= 1'b0;
			regen_inhibit_output_o <= 1'b0;
			regen_force_output_o   <= 1'b0;
			regen_active_flags_o   <= 3'h0;
			filter_need_flags_o    <= 4'h0;
			pump_output_o          <= 1'b0;
			valve_output_o         <= 1'b0;
			pump_failure_alarm_o   <= 1'b0;
			pump_started_event_o   <= 1'b0;
			pump_stopped_event_o   <= 1'b0;
		end else begin
			regen_consent_o <= cfg_r[`ATP_CFG_CONS_IN] ? regen_consent_input_i
				: !generator_breaker_closed_i;
			overspeed_suppress_o <= !generator_breaker_closed_i
				&& can_regen_status_i == `ATP_RS_ACTIVE;
			can_spn3695_inhibit_o  <= mode_eff == `ATP_RG_INHIBIT;
			can_spn3696_force_o    <= mode_eff == `ATP_RG_FORCE;
			regen_inhibit_output_o <= mode_eff == `ATP_RG_INHIBIT;
			regen_force_output_o   <= mode_eff == `ATP_RG_FORCE;
			regen_active_flags_o   <= (can_regen_status_i == `ATP_RS_UNDEF) ? 3'h0
				: 3'h1 << can_regen_status_i;
			filter_need_flags_o    <= 4'h1 << can_filter_status_i;
			pump_output_o  <= pump_en && vs_r == VS_RUN && pump_cmd_r;
			valve_output_o <= pump_en && cfg_r[`ATP_CFG_VALV_OUT] && vs_r != VS_IDLE;
			pump_failure_alarm_o <= run_lat_r;
			pump_started_event_o <= cfg_r[`ATP_CFG_EVT_EN] && pump_cmd_nxt && !pump_cmd_r;
			pump_stopped_event_o <= cfg_r[`ATP_CFG_EVT_EN] && !pump_cmd_nxt && pump_cmd_r;
		end
	end

	// Event counters give software a record of each logged transition.
	always @(posedge clk_i) begin
		if (rst_i) begin
			evt_start_cnt_r <= 16'h0;
			evt_stop_cnt_r  <= 16'h0;
		end else begin
			if (pump_started_event_o) begin
				evt_start_cnt_r <= evt_start_cnt_r + 16'h1;
			end
			if (pump_stopped_event_o) begin
				evt_stop_cnt_r <= evt_stop_cnt_r + 16'h1;
			end
		end
	end

	// Wishbone answer one cycle after the strobe; unmapped reads return zero.
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req && !wb_we_i) begin
				case (wb_adr_i)
					`ATP_ADR_CFG:   wb_dat_o <= {24'h0, cfg_r};
					`ATP_ADR_REGEN: wb_dat_o <= {force_max_r, 14'h0, mode_eff};
					`ATP_ADR_PUMP:  wb_dat_o <= {run_max_r, 9'h0, src_sel_r, 2'h0, pump_mode_r};
					`ATP_ADR_THR:   wb_dat_o <= {16'h0, thr_stop_r, thr_start_r};
					`ATP_ADR_DELAY: wb_dat_o <= {16'h0, dly_close_r, dly_open_r};
					`ATP_ADR_STAT:  wb_dat_o <= {17'h0, vs_r, lvl_stat, filter_need_flags_o,
						regen_active_flags_o, valve_output_o, pump_cmd_r};
					`ATP_ADR_ACK:   wb_dat_o <= {29'h0, run_lat_r, src_lat_r, off_lat_r};
					`ATP_ADR_EVT:   wb_dat_o <= {evt_stop_cnt_r, evt_start_cnt_r};
					default:        wb_dat_o <= 32'h0;
				endcase
			end
		end
	end

endmodule // atp_ctrl
`default_nettype wire

// ===== dv/atp_ecu_model.sv
// Behavioural engine unit answering regeneration commands with status values.
`timescale 1ns/10ps
`default_nettype none

module atp_ecu_model (
	input  wire logic       clk_i,
	input  wire logic       inhibit_i,
	input  wire logic       force_i,
	input  wire logic [1:0] want_i,
	input  wire logic [1:0] filter_i,
	input  wire logic [7:0] level_i,
	output var  logic [1:0] regen_status_o,
	output var  logic [1:0] filter_status_o,
	output var  logic [7:0] tank_level_o
);
	// Inhibit beats force, as a real unit refuses to regenerate while inhibited.
	always @(posedge clk_i) begin
		if (inhibit_i)
			regen_status_o <= 2'h0;
		else if (force_i)
			regen_status_o <= 2'h1;
		else
			regen_status_o <= want_i;
		filter_status_o <= filter_i;
		tank_level_o <= level_i;
	end
endmodule // atp_ecu_model

`default_nettype wire

// ===== dv/atp_ctrl_assertions.sv
// Concurrent checks on the port behaviour of the aftertreatment block.
`timescale 1ns/10ps
`default_nettype none

module atp_ctrl_assertions (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       generator_breaker_closed_i,
	input wire logic [1:0] can_regen_status_i,
	input wire logic [1:0] can_filter_status_i,
	input wire logic [2:0] regen_active_flags_o,
	input wire logic [3:0] filter_need_flags_o,
	input wire logic       overspeed_suppress_o,
	input wire logic       can_spn3695_inhibit_o,
	input wire logic       can_spn3696_force_o,
	input wire logic       regen_inhibit_output_o,
	input wire logic       regen_force_output_o,
	input wire logic       pump_output_o,
	input wire logic       pump_failure_alarm_o,
	input wire logic       pump_started_event_o,
	input wire logic       pump_stopped_event_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Bus raises the acknowledge exactly one cycle after taking a request.
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("Bus request not answered one cycle later.");
	// Status decodes lag their inputs by one stage; skip the edge leaving reset.
	a_regen_decode: assert property (!$past(rst_i) |-> regen_active_flags_o ==
		($past(can_regen_status_i) == 2'h3 ? 3'h0 : 3'h1 << $past(can_regen_status_i)))
		else $error("Regeneration status flags wrong.");
	a_filter_decode: assert property (!$past(rst_i) |->
		filter_need_flags_o == 4'h1 << $past(can_filter_status_i))
		else $error("Filter status flags wrong.");
	a_suppress_cause: assert property (!$past(rst_i) |-> overspeed_suppress_o ==
		(!$past(generator_breaker_closed_i) && $past(can_regen_status_i) == 2'h1))
		else $error("Overspeed suppression wrong.");
	a_cmd_exclusive: assert property (!(can_spn3695_inhibit_o && can_spn3696_force_o))
		else $error("Inhibit and force both sent.");
	a_discrete_copy: assert property ((regen_inhibit_output_o == can_spn3695_inhibit_o)
		&& (regen_force_output_o == can_spn3696_force_o))
		else $error("Discrete commands differ from bus commands.");
	a_alarm_stops: assert property (pump_failure_alarm_o && $past(pump_failure_alarm_o, 3)
		|-> !pump_output_o)
		else $error("Pump runs with failure alarm latched.");
	a_start_pulse: assert property (pump_started_event_o |=> !pump_started_event_o)
		else $error("Start event longer than one cycle.");
	a_stop_event: assert property (pump_stopped_event_o |-> ##[0:2] !pump_output_o)
		else $error("Stop event without pump stopping.");

	c_pump_run: cover property ($rose(pump_output_o));
	c_alarm: cover property ($rose(pump_failure_alarm_o));
	c_force: cover property ($rose(can_spn3696_force_o));
endmodule // atp_ctrl_assertions

bind atp_ctrl atp_ctrl_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.generator_breaker_closed_i(generator_breaker_closed_i),
	.can_regen_status_i(can_regen_status_i), .can_filter_status_i(can_filter_status_i),
	.regen_active_flags_o(regen_active_flags_o), .filter_need_flags_o(filter_need_flags_o),
	.overspeed_suppress_o(overspeed_suppress_o), .can_spn3695_inhibit_o(can_spn3695_inhibit_o),
	.can_spn3696_force_o(can_spn3696_force_o), .regen_inhibit_output_o(regen_inhibit_output_o),
	.regen_force_output_o(regen_force_output_o), .pump_output_o(pump_output_o),
	.pump_failure_alarm_o(pump_failure_alarm_o), .pump_started_event_o(pump_started_event_o),
	.pump_stopped_event_o(pump_stopped_event_o));

`default_nettype wire

// ===== dv/aftertreatment_regen_fluid_pump_ctrl_tb.sv
// Self-checking bench for the aftertreatment block with an engine unit model.
`timescale 1ns/10ps
`default_nettype none
`include "atp_regs.vh"

module aftertreatment_regen_fluid_pump_ctrl_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] dti = 32'h0;
	logic        brk = 1'b0;
	logic        cns = 1'b0;
	logic        inh = 1'b0;
	logic        frc = 1'b0;
	logic        stc = 1'b0;
	logic        spc = 1'b0;
	logic        off = 1'b0;
	logic [4:0]  src = 5'h1f;
	logic [1:0]  want = 2'h0;
	logic [1:0]  fil = 2'h0;
	logic [7:0]  lvl = 8'h32;
	logic [31:0] dto, rd;
	logic [1:0]  rs, fs;
	logic [7:0]  ls;
	logic [2:0]  raf;
	logic [3:0]  fnf;
	logic        ack, con, sup, cinh, cfrc, dinh, dfrc, pump, valve, alarm;
	int          n_mismatch = 0;
	int          n_tests = 0;

	// One tick is ten cycles so second-based timers finish quickly.
	atp_ctrl #(.TICK_CY(10)) DUT (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dti), .wb_dat_o(dto),
		.wb_ack_o(ack), .generator_breaker_closed_i(brk), .regen_consent_input_i(cns),
		.regen_inhibit_input_i(inh), .regen_force_input_i(frc), .can_regen_status_i(rs),
		.can_filter_status_i(fs), .can_tank_level_i(ls), .start_level_contact_i(stc),
		.stop_level_contact_i(spc), .ctrl_off_mode_i(off), .source_avail_i(src),
		.regen_consent_o(con), .overspeed_suppress_o(sup), .can_spn3695_inhibit_o(cinh),
		.can_spn3696_force_o(cfrc), .regen_inhibit_output_o(dinh),
		.regen_force_output_o(dfrc), .regen_active_flags_o(raf), .filter_need_flags_o(fnf),
		.pump_output_o(pump), .valve_output_o(valve), .pump_failure_alarm_o(alarm),
		.pump_started_event_o(), .pump_stopped_event_o());

	atp_ecu_model u_ecu (.clk_i(clk), .inhibit_i(cinh), .force_i(cfrc), .want_i(want),
		.filter_i(fil), .level_i(lvl), .regen_status_o(rs), .filter_status_o(fs),
		.tank_level_o(ls));

	// Free-running system clock.
	initial begin
		forever #5 clk = ~clk;
	end

	// Classic bus cycle held until the acknowledge edge, then one idle cycle.
	// Only the watchdog ends a wait for the acknowledge.
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dti <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		rd = dto;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task rchk(input logic [3:0] a, input logic [31:0] e, input string nm);
		wb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask

	task idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Bounded wait; the caller compares afterwards.
	task wait_pump(input logic v, input int lim);
		for (int k = 0; k < lim && pump !== v; k++)
			@(posedge clk);
	endtask

	task print_verdict;
		$display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Watchdog well beyond the roughly five hundred cycles the sequence needs.
	initial begin
		repeat (6000) @(posedge clk);
		n_mismatch++;
		print_verdict;
	end

	initial begin
		int k;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rchk(`ATP_ADR_CFG, 32'h10, "cfg");
		rchk(`ATP_ADR_THR, 32'h5014, "thr");
		rchk(`ATP_ADR_DELAY, 32'h0202, "delay");
		rchk(4'h8, 32'h0, "unmapped");
		chk("consent open", 1, con);
		brk <= 1'b1;
		idle(3);
		chk("consent closed", 0, con);
		wb(1'b1, `ATP_ADR_CFG, 32'h11);
		cns <= 1'b1;
		idle(3);
		chk("consent input", 1, con);
		wb(1'b1, `ATP_ADR_CFG, 32'h10);
		brk <= 1'b0;
		wb(1'b1, `ATP_ADR_REGEN, {30'h0, `ATP_RG_INHIBIT});
		chk("inhibit cmds", 4'b1010, {cinh, cfrc, dinh, dfrc});
		wb(1'b1, `ATP_ADR_REGEN, {30'h0, `ATP_RG_AUTO});
		chk("auto cmds", 4'b0000, {cinh, cfrc, dinh, dfrc});
		// Forcing for three seconds with the breaker open.
		wb(1'b1, `ATP_ADR_REGEN, {16'h3, 14'h0, `ATP_RG_FORCE});
		idle(15);
		chk("force cmds", 4'b0101, {cinh, cfrc, dinh, dfrc});
		chk("suppress", 1, sup);
		for (k = 0; k < 30 && cfrc === 1'b1; k++)
			@(posedge clk);
		chk("force ends", 0, cfrc);
		rchk(`ATP_ADR_REGEN, 32'h0003_0000, "mode back");
		wb(1'b1, `ATP_ADR_CFG, 32'h16);
		inh <= 1'b1;
		wb(1'b1, `ATP_ADR_REGEN, 32'h1);
		wb(1'b0, `ATP_ADR_REGEN, 32'h0);
		chk("mode from input", 2, rd[1:0]);
		chk("inhibit input", 1, cinh);
		// Both inputs raised: inhibit takes the mode, then force alone.
		frc <= 1'b1;
		idle(3);
		chk("inhibit wins", 2'b10, {cinh, cfrc});
		inh <= 1'b0;
		idle(3);
		chk("force input", 2'b01, {cinh, cfrc});
		frc <= 1'b0;
		for (k = 0; k < 4; k++) begin
			want <= k[1:0];
			fil <= k[1:0];
			idle(4);
			chk("regen flags", k < 3 ? 3'h1 << k : 3'h0, raf);
			chk("filter flags", 4'h1 << k, fnf);
		end
		want <= 2'h0;
		// Automatic pump at the threshold boundaries, start 20 and stop 80.
		wb(1'b1, `ATP_ADR_CFG, 32'h90);
		wb(1'b1, `ATP_ADR_PUMP, 32'h42);
		lvl <= 8'h14;
		idle(10);
		chk("at start", 0, pump);
		lvl <= 8'h13;
		wait_pump(1'b1, 20);
		chk("below start", 1, pump);
		lvl <= 8'h50;
		idle(10);
		chk("at stop", 1, pump);
		lvl <= 8'h51;
		wait_pump(1'b0, 20);
		chk("above stop", 0, pump);
		rchk(`ATP_ADR_EVT, 32'h0001_0001, "events");
		lvl <= 8'h32;
		wb(1'b1, `ATP_ADR_PUMP, 32'h41);
		wait_pump(1'b1, 20);
		chk("manual on", 1, pump);
		lvl <= 8'h05;
		wb(1'b1, `ATP_ADR_PUMP, 32'h40);
		wait_pump(1'b0, 20);
		chk("manual off", 0, pump);
		// Contacts say the tank is full although the bus level is low.
		wb(1'b1, `ATP_ADR_CFG, 32'h98);
		wb(1'b1, `ATP_ADR_PUMP, 32'h42);
		idle(10);
		chk("contacts full", 0, pump);
		stc <= 1'b1;
		spc <= 1'b1;
		wait_pump(1'b1, 20);
		chk("contacts low", 1, pump);
		wb(1'b1, `ATP_ADR_CFG, 32'h90);
		off <= 1'b1;
		idle(30);
		chk("off short", 1, pump);
		wait_pump(1'b0, 40);
		chk("off long", 0, pump);
		off <= 1'b0;
		idle(20);
		chk("off latched", 0, pump);
		rchk(`ATP_ADR_ACK, 32'h1, "off anomaly");
		wb(1'b1, `ATP_ADR_ACK, 32'h1);
		wait_pump(1'b1, 20);
		chk("off acked", 1, pump);
		wb(1'b1, `ATP_ADR_PUMP, {25'h0, `ATP_SRC_GEN, 4'h2});
		src <= 5'h1e;
		idle(30);
		chk("source short", 1, pump);
		wait_pump(1'b0, 40);
		chk("source lost", 0, pump);
		src <= 5'h1f;
		idle(2); // Let the outage timer clear so the new cause does not beat the acknowledge.
		wb(1'b1, `ATP_ADR_ACK, 32'h2);
		wb(1'b1, `ATP_ADR_PUMP, 32'h0002_0042);
		wait_pump(1'b0, 40);
		chk("run limit", 2'b01, {pump, alarm});
		wb(1'b1, `ATP_ADR_PUMP, 32'h42);
		wb(1'b1, `ATP_ADR_ACK, 32'h4);
		chk("alarm cleared", 0, alarm);
		// Valve opens two seconds ahead of the pump.
		lvl <= 8'h51;
		wait_pump(1'b0, 20);
		wb(1'b1, `ATP_ADR_CFG, 32'hb0);
		idle(40);
		lvl <= 8'h05;
		for (k = 0; k < 40 && valve !== 1'b1; k++)
			@(posedge clk);
		chk("valve first", 2'b10, {valve, pump});
		for (k = 0; k < 40 && pump !== 1'b1; k++)
			@(posedge clk);
		chk("valve lead", 1, k >= 10 && k <= 30);
		// Valve stays open two seconds after the pump stops.
		lvl <= 8'h51;
		wait_pump(1'b0, 20);
		for (k = 0; k < 40 && valve !== 1'b0; k++)
			@(posedge clk);
		chk("valve lag", 1, k >= 10 && k <= 30);
		print_verdict;
	end
endmodule // aftertreatment_regen_fluid_pump_ctrl_tb

`default_nettype wire
